// >>> rrseq_defs.svh
// rrseq_defs.svh: offsets, field positions, codes and timing of the rate sequencer
// assumes: included by bare name from the package and design files
`ifndef RRSEQ_DEFS_SVH
`define RRSEQ_DEFS_SVH

// ****************************************
// apb register byte offsets; rrseq_apb decodes only ctrl, status and phase
// ****************************************
`define RRSEQ_OFF_CTRL      12'h000
`define RRSEQ_OFF_STATUS    12'h004
`define RRSEQ_OFF_CFG_ADDR  12'h008
`define RRSEQ_OFF_CFG_DATA  12'h00C
`define RRSEQ_OFF_RDATA     12'h010
`define RRSEQ_OFF_PHASE     12'h014

// ctrl fields
`define RRSEQ_CTRL_GO       0
`define RRSEQ_CTRL_TGT_LO   4
`define RRSEQ_CTRL_TGT_HI   5
`define RRSEQ_CTRL_INIT     8
`define RRSEQ_CTRL_RST      32'h0000_0000

// status fields
`define RRSEQ_ST_BUSY       0
`define RRSEQ_ST_DONE       1
`define RRSEQ_ST_CUR_LO     4
`define RRSEQ_ST_CUR_HI     5
`define RRSEQ_ST_LINK_LO    8
`define RRSEQ_ST_LINK_HI    11

// ****************************************
// link status word values
// ****************************************
`define RRSEQ_LINK_UP       4'h7
`define RRSEQ_LINK_PASS     4'hF

// ****************************************
// serdes attribute codes and on/off values
// ****************************************
`define RRSEQ_ATTR_SERDES   16'h0001
`define RRSEQ_ATTR_PHASE    16'h000E
`define RRSEQ_ATTR_LOOP     16'h0008
`define RRSEQ_ATTR_OFF      16'h0000
`define RRSEQ_ATTR_ON       16'h0001

// ****************************************
// timing
// ****************************************
`define RRSEQ_CLK_MHZ       20
`define RRSEQ_RST_NS        200

`endif

// >>> rrseq_pkg.sv
// rrseq_pkg.sv: types shared by the rate sequencer modules
// assumes: rrseq_defs.svh on the include path
package rrseq_pkg;
  `include "rrseq_defs.svh"

  // target line modes
  typedef enum logic [1:0] {
    RRSEQ_M24_FEC,
    RRSEQ_M24_NOFEC,
    RRSEQ_M10,
    RRSEQ_M98
  } rrseq_mode_t;

  // kinds of configuration access towards the phy
  typedef enum logic [2:0] {
    RRSEQ_OP_ATTR,
    RRSEQ_OP_ANALOG_RST,
    RRSEQ_OP_TX_RATIO,
    RRSEQ_OP_RX_RATIO,
    RRSEQ_OP_REPROG,
    RRSEQ_OP_CLR_STATS,
    RRSEQ_OP_PKTGEN,
    RRSEQ_OP_REFMUX
  } rrseq_op_t;
endpackage : rrseq_pkg

// >>> rrseq_cfg_if.sv
// rrseq_cfg_if.sv: one configuration access between sequencer and its port engine
// assumes: single clock domain, one outstanding request at a time
`timescale 1ns/1ns
`default_nettype none
interface rrseq_cfg_if;
  import rrseq_pkg::*;
  logic        req;
  rrseq_op_t   op;
  logic [15:0] code;
  logic [31:0] value;
  logic        ack;

  modport seq (output req, output op, output code, output value, input ack);
  modport eng (input req, input op, input code, input value, output ack);
endinterface : rrseq_cfg_if
`default_nettype wire

// >>> rrseq_cfg_port.sv
// rrseq_cfg_port.sv: turns one sequencer step into a handshake on the phy config port
// assumes: phy answers each cfg_req with cfg_done, any number of cycles later
`timescale 1ns/1ns
`default_nettype none
module rrseq_cfg_port
  import rrseq_pkg::*;
(
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // sequencer side
  rrseq_cfg_if.eng    cfg,
  // phy configuration port
  output logic        cfg_req,
  output logic [2:0]  cfg_op,
  output logic [15:0] cfg_code,
  output logic [31:0] cfg_value,
  input  wire logic   cfg_done
);

  logic busy_reg;
  logic ack_reg;

  // request held steady until the phy answers, then one-cycle ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      cfg_op    <= 3'h0;
      cfg_code  <= 16'h0000;
      cfg_value <= 32'h0000_0000;
    end else begin
      ack_reg <= 1'b0;
      if (!busy_reg && cfg.req && !ack_reg) begin
        busy_reg  <= 1'b1;
        cfg_op    <= cfg.op;
        cfg_code  <= cfg.code;
        cfg_value <= cfg.value;
      end else if (busy_reg && cfg_done) begin
        busy_reg <= 1'b0;
        ack_reg  <= 1'b1;
      end
    end
  end

  assign cfg_req = busy_reg;
  assign cfg.ack = ack_reg;

endmodule : rrseq_cfg_port
`default_nettype wire

// >>> rrseq_apb.sv
// rrseq_apb.sv: apb slave holding the sequencer's command and status registers
// assumes: apb3 master, zero wait states, 32-bit aligned words
`timescale 1ns/1ns
`default_nettype none
`include "rrseq_defs.svh"
module rrseq_apb
  import rrseq_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // to sequencer
  output logic             go_pulse,
  output logic             init_pulse,
  output rrseq_mode_t      target,
  output logic [31:0]      phase_val,
  // from sequencer
  input  wire logic [31:0] status_word
);

  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] ctrl_reg;
  logic [31:0] phase_reg;

  assign wr_en = psel && penable && pwrite;
  // captured in setup so the word stands through the whole access phase
  assign rd_en = psel && !penable && !pwrite;
  assign hit   = (paddr == `RRSEQ_OFF_CTRL) || (paddr == `RRSEQ_OFF_STATUS)
              || (paddr == `RRSEQ_OFF_PHASE);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `RRSEQ_CTRL_RST;
      phase_reg  <= 32'h0000_0000;
      go_pulse   <= 1'b0;
      init_pulse <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      go_pulse   <= wr_en && (paddr == `RRSEQ_OFF_CTRL) && pwdata[`RRSEQ_CTRL_GO];
      init_pulse <= wr_en && (paddr == `RRSEQ_OFF_CTRL) && pwdata[`RRSEQ_CTRL_INIT];
      if (wr_en && paddr == `RRSEQ_OFF_CTRL) ctrl_reg <= pwdata & 32'h0000_0030;
      if (wr_en && paddr == `RRSEQ_OFF_PHASE) phase_reg <= pwdata;
      if (rd_en) begin
        case (paddr)
          `RRSEQ_OFF_CTRL:   prdata <= ctrl_reg;
          `RRSEQ_OFF_STATUS: prdata <= status_word;
          `RRSEQ_OFF_PHASE:  prdata <= phase_reg;
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign target    = rrseq_mode_t'(ctrl_reg[`RRSEQ_CTRL_TGT_HI:`RRSEQ_CTRL_TGT_LO]);
  assign phase_val = phase_reg;

endmodule : rrseq_apb
`default_nettype wire

// >>> rate_reconfig_sequencer.sv
// rate_reconfig_sequencer.sv: host-side sequencer that brings up the phy and moves
// it between line rates, running a traffic test after start-up and after each rate change, in internal loopback after rate changes
// assumes: phy config port answers every request; status word synchronous to pclk
// Contract
// [R1] assert all resets, release config, tx, rx
// [R2] after serdes enable wait status 0x7
// [R3] clear counters, then enable packet generator
// [R4] wait status 0xF with checker pass
// [R5] disable generator after pass
// [R6] rate change: resets, then serdes off 0x0001
// [R7] analog reset before rate settings
// [R8] 24G/10G: rewrite tx ratio
// [R9] 24G/10G: rewrite rx ratio
// [R10] reprogram mac, fec, transceiver registers
// [R11] phase adjust, attribute 0x000E
// [R12] re-enable serdes with 0x0001
// [R13] internal loopback, attribute 0x0008
// [R14] release resets, repeat link test
// [R15] fec toggle at 24G skips ratios
// [R16] modes 24G fec, 24G, 10G, 9.8G
// [R17] 10G to 9.8G switches refclk mux
// [R18] refclk switch: ctrl clk alt, input, back
// [R19] one access at a time, strictly ordered
`timescale 1ns/1ns
`default_nettype none
`include "rrseq_defs.svh"
module rate_reconfig_sequencer
  import rrseq_pkg::*;
#(
  parameter int RST_HOLD_NS = `RRSEQ_RST_NS
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // phy resets
  output logic             config_reset_n,
  output logic             transmit_reset_n,
  output logic             receive_reset_n,
  // phy configuration port
  output logic             cfg_req,
  output logic [2:0]       cfg_op,
  output logic [15:0]      cfg_code,
  output logic [31:0]      cfg_value,
  input  wire logic        cfg_done,
  // link status word: {checker pass, core ready, rx_lock_flag, rx_coding_ready}
  input  wire logic [3:0]  link_status_word
);

  // ****************************************
  // timing
  // ****************************************
  localparam int RST_CYC_RAW = (RST_HOLD_NS * `RRSEQ_CLK_MHZ + 999) / 1000;
  localparam int RST_CYC     = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam logic [7:0] RST_CYC_W = 8'(RST_CYC);

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE, S_ALL_RST, S_REL_CFG, S_REL_TXRX, S_SERDES_ON0,
    S_WAIT_UP, S_CLR, S_GEN_ON, S_WAIT_PASS, S_GEN_OFF,
    S_RC_RST, S_SERDES_OFF, S_MUX_ALT, S_MUX_IN, S_MUX_BACK,
    S_ANALOG, S_TXR, S_RXR, S_REPROG, S_PHASE, S_SERDES_ON,
    S_LOOP, S_RC_REL
  } rrseq_state_t;

  rrseq_state_t state_reg;
  rrseq_state_t state_next;
  rrseq_mode_t  cur_reg;
  rrseq_mode_t  tgt_reg;
  logic [7:0]   cnt_reg;
  logic         done_reg;
  logic         req_reg;
  logic         go_pulse;
  logic         init_pulse;
  rrseq_mode_t  target;
  logic [31:0]  phase_val;
  logic [31:0]  status_word;

  rrseq_cfg_if cfg_bus ();

  // ****************************************
  // register slave and port engine
  // ****************************************
  rrseq_apb u_apb (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .go_pulse    (go_pulse),
    .init_pulse  (init_pulse),
    .target      (target),
    .phase_val   (phase_val),
    .status_word (status_word)
  );

  rrseq_cfg_port u_port (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (cfg_bus.eng),
    .cfg_req   (cfg_req),
    .cfg_op    (cfg_op),
    .cfg_code  (cfg_code),
    .cfg_value (cfg_value),
    .cfg_done  (cfg_done)
  );

  // ****************************************
  // decode
  // ****************************************
  logic busy;
  logic ratio_change;
  logic to_98;
  logic acked;
  logic hold_done;
  logic op_state;

  assign busy         = (state_reg != S_IDLE);
  // moves into or out of 10G need new ratios, except 10G to 9.8G; fec toggles at 24G and moves to 9.8G do not
  assign ratio_change = (cur_reg == RRSEQ_M10) != (tgt_reg == RRSEQ_M10)
                     && tgt_reg != RRSEQ_M98;                         // [R8] [R9] [R15]
  assign to_98        = (tgt_reg == RRSEQ_M98);                       // [R17]
  assign acked        = cfg_bus.ack;
  assign hold_done    = (cnt_reg == RST_CYC_W);
  assign status_word  = {20'h0_0000, link_status_word, 2'b00, cur_reg, 2'b00,
                         done_reg, busy};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (init_pulse) state_next = S_ALL_RST;
        else if (go_pulse && target != cur_reg) state_next = S_RC_RST; // [R16]
      end
      S_ALL_RST:    if (hold_done) state_next = S_REL_CFG;              // [R1]
      S_REL_CFG:    if (hold_done) state_next = S_REL_TXRX;             // [R1]
      S_REL_TXRX:   if (hold_done) state_next = S_SERDES_ON0;           // [R1]
      S_SERDES_ON0: if (acked) state_next = S_WAIT_UP;
      S_WAIT_UP: begin
        if (link_status_word == `RRSEQ_LINK_UP) state_next = S_CLR;     // [R2]
      end
      S_CLR:        if (acked) state_next = S_GEN_ON;                   // [R3]
      S_GEN_ON:     if (acked) state_next = S_WAIT_PASS;                // [R3]
      S_WAIT_PASS: begin
        if (link_status_word == `RRSEQ_LINK_PASS) state_next = S_GEN_OFF; // [R4]
      end
      S_GEN_OFF:    if (acked) state_next = S_IDLE;                     // [R5]
      S_RC_RST:     if (hold_done) state_next = S_SERDES_OFF;           // [R6]
      S_SERDES_OFF: if (acked) state_next = to_98 ? S_MUX_ALT : S_ANALOG; // [R17]
      S_MUX_ALT:    if (acked) state_next = S_MUX_IN;                   // [R18]
      S_MUX_IN:     if (acked) state_next = S_MUX_BACK;                 // [R18]
      S_MUX_BACK:   if (acked) state_next = S_ANALOG;                   // [R18]
      S_ANALOG:     if (acked) state_next = ratio_change ? S_TXR : S_REPROG; // [R7] [R15]
      S_TXR:        if (acked) state_next = S_RXR;                      // [R8]
      S_RXR:        if (acked) state_next = S_REPROG;                   // [R9]
      S_REPROG:     if (acked) state_next = S_PHASE;                    // [R10]
      S_PHASE:      if (acked) state_next = S_SERDES_ON;                // [R11]
      S_SERDES_ON:  if (acked) state_next = S_LOOP;                     // [R12]
      S_LOOP:       if (acked) state_next = S_RC_REL;                   // [R13]
      S_RC_REL:     if (hold_done) state_next = S_WAIT_UP;              // [R14]
      default:      state_next = S_IDLE;
    endcase
  end

  // ****************************************
  // request for the current step
  // ****************************************
  always_comb begin
    op_state       = 1'b1;
    cfg_bus.op     = RRSEQ_OP_ATTR;
    cfg_bus.code   = `RRSEQ_ATTR_SERDES;
    cfg_bus.value  = 32'h0000_0000;
    case (state_reg)
      S_SERDES_ON0, S_SERDES_ON: begin                                  // [R12]
        cfg_bus.value = {16'h0000, `RRSEQ_ATTR_ON};
      end
      S_SERDES_OFF: cfg_bus.value = {16'h0000, `RRSEQ_ATTR_OFF};        // [R6]
      S_CLR:        cfg_bus.op = RRSEQ_OP_CLR_STATS;                    // [R3]
      S_GEN_ON: begin
        cfg_bus.op    = RRSEQ_OP_PKTGEN;
        cfg_bus.value = 32'h0000_0001;
      end
      S_GEN_OFF:    cfg_bus.op = RRSEQ_OP_PKTGEN;                       // [R5]
      S_MUX_ALT, S_MUX_IN, S_MUX_BACK: begin
        // value 0: ctrl clock to alternate, 1: ref input, 2: ctrl clock back
        cfg_bus.op    = RRSEQ_OP_REFMUX;
        cfg_bus.value = (state_reg == S_MUX_ALT) ? 32'h0000_0000 :
                        (state_reg == S_MUX_IN)  ? 32'h0000_0001 : 32'h0000_0002;
      end
      S_ANALOG:     cfg_bus.op = RRSEQ_OP_ANALOG_RST;                   // [R7]
      S_TXR: begin
        cfg_bus.op    = RRSEQ_OP_TX_RATIO;
        cfg_bus.value = {30'h0000_0000, tgt_reg};
      end
      S_RXR: begin
        cfg_bus.op    = RRSEQ_OP_RX_RATIO;
        cfg_bus.value = {30'h0000_0000, tgt_reg};
      end
      S_REPROG: begin
        cfg_bus.op    = RRSEQ_OP_REPROG;
        cfg_bus.value = {30'h0000_0000, tgt_reg};
      end
      S_PHASE: begin
        cfg_bus.code  = `RRSEQ_ATTR_PHASE;                              // [R11]
        cfg_bus.value = phase_val;
      end
      S_LOOP: begin
        cfg_bus.code  = `RRSEQ_ATTR_LOOP;                               // [R13]
        cfg_bus.value = 32'h0000_0001;
      end
      default: op_state = 1'b0;
    endcase
  end

  // one request per step; dropped on ack so the next step starts fresh
  assign cfg_bus.req = req_reg && op_state;                             // [R19]

  // ****************************************
  // state and resets
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cur_reg   <= RRSEQ_M24_FEC;
      tgt_reg   <= RRSEQ_M24_FEC;
      cnt_reg   <= 8'h00;
      done_reg  <= 1'b0;
      req_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg || hold_done) ? 8'h00 : cnt_reg + 8'h01;
      req_reg   <= (state_next == state_reg) && !acked;
      if (state_reg == S_IDLE && go_pulse && target != cur_reg) begin
        tgt_reg  <= target;
        done_reg <= 1'b0;
      end
      if (state_reg == S_IDLE && init_pulse) done_reg <= 1'b0;
      if (state_reg == S_GEN_OFF && acked) begin
        cur_reg  <= tgt_reg;
        done_reg <= 1'b1;
      end
    end
  end

  // resets held low until the start-up walk releases them, or S_RC_REL releases tx and rx
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reset_n   <= 1'b0;
      transmit_reset_n <= 1'b0;
      receive_reset_n  <= 1'b0;
    end else begin
      case (state_reg)
        S_ALL_RST: begin                                                // [R1]
          config_reset_n   <= 1'b0;
          transmit_reset_n <= 1'b0;
          receive_reset_n  <= 1'b0;
        end
        S_REL_CFG:  config_reset_n <= 1'b1;                             // [R1]
        S_REL_TXRX, S_RC_REL: begin                                     // [R14]
          transmit_reset_n <= 1'b1;
          receive_reset_n  <= 1'b1;
        end
        S_RC_RST: begin                                                 // [R6]
          transmit_reset_n <= 1'b0;
          receive_reset_n  <= 1'b0;
        end
        default: begin
          config_reset_n   <= config_reset_n;
          transmit_reset_n <= transmit_reset_n;
          receive_reset_n  <= receive_reset_n;
        end
      endcase
    end
  end

endmodule : rate_reconfig_sequencer
`default_nettype wire

// >>> rrseq_asserts.sv
// rrseq_asserts.sv: timing checks on the sequencer's phy side ports
// assumes: bound to rate_reconfig_sequencer, single pclk domain
`timescale 1ns/1ns
`default_nettype none
module rrseq_asserts #(
  parameter int RST_HOLD_NS = 200
)(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // phy resets
  input wire logic        config_reset_n,
  input wire logic        transmit_reset_n,
  input wire logic        receive_reset_n,
  // phy configuration port
  input wire logic        cfg_req,
  input wire logic [2:0]  cfg_op,
  input wire logic [15:0] cfg_code,
  input wire logic [31:0] cfg_value,
  input wire logic        cfg_done,
  input wire logic [3:0]  link_status_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_req_hold: assert property (
    cfg_req && !cfg_done |=> cfg_req && $stable({cfg_op, cfg_code, cfg_value}))
    else $error("config request changed before done");
  a_req_drop: assert property (
    cfg_req && cfg_done |=> !cfg_req)
    else $error("config request held after done");
  a_idle_gap: assert property (
    $fell(cfg_req) |-> !cfg_req ##1 !cfg_req)
    else $error("config requests too close");
  a_gen_on_up: assert property (
    $rose(cfg_req) && cfg_op == 3'd6 && cfg_value[0] |-> link_status_word == 4'h7)
    else $error("generator enabled without link up");
  a_gen_off_pass: assert property (
    $rose(cfg_req) && cfg_op == 3'd6 && !cfg_value[0] |-> link_status_word == 4'hF)
    else $error("generator stopped without pass");
  a_off_in_reset: assert property (
    $rose(cfg_req) && cfg_op == 3'd0 && cfg_code == 16'h0001 && cfg_value == 32'h0
    |-> !transmit_reset_n && !receive_reset_n)
    else $error("serdes disabled outside reset");
  a_attr_codes: assert property (
    cfg_req && cfg_op == 3'd0 |-> cfg_code inside {16'h0001, 16'h000E, 16'h0008})
    else $error("unknown attribute code");
  a_cfg_in_reset: assert property (
    cfg_req && cfg_op inside {3'd1, 3'd2, 3'd3, 3'd4, 3'd7}
    |-> !transmit_reset_n && !receive_reset_n)
    else $error("rate setting outside reset");
  a_release_order: assert property (
    $rose(transmit_reset_n) |-> receive_reset_n && config_reset_n)
    else $error("reset release out of order");

  c_pass: cover property ($rose(cfg_req) && cfg_op == 3'd6 && !cfg_value[0]);
  c_ratio: cover property ($rose(cfg_req) && cfg_op == 3'd2);
  c_refmux: cover property ($rose(cfg_req) && cfg_op == 3'd7);
endmodule : rrseq_asserts

bind rate_reconfig_sequencer rrseq_asserts #(.RST_HOLD_NS(RST_HOLD_NS)) rrseq_asserts_inst (
  .pclk(pclk), .presetn(presetn), .config_reset_n(config_reset_n),
  .transmit_reset_n(transmit_reset_n), .receive_reset_n(receive_reset_n),
  .cfg_req(cfg_req), .cfg_op(cfg_op), .cfg_code(cfg_code), .cfg_value(cfg_value),
  .cfg_done(cfg_done), .link_status_word(link_status_word));
`default_nettype wire

// >>> rrseq_phy_model.sv
// rrseq_phy_model.sv: behavioural phy core, transceiver and traffic checker
// assumes: one config access at a time, answered after a short or long wait
`timescale 1ns/1ns
`default_nettype none
module rrseq_phy_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        slow,
  // resets and config port
  input wire logic        config_reset_n,
  input wire logic        transmit_reset_n,
  input wire logic        receive_reset_n,
  input wire logic        cfg_req,
  input wire logic [2:0]  cfg_op,
  input wire logic [15:0] cfg_code,
  input wire logic [31:0] cfg_value,
  output logic            cfg_done,
  output logic [3:0]      link_status_word
);
  logic [2:0] wait_reg;
  logic [3:0] up_reg;
  logic       serdes_reg;
  logic       gen_reg;
  logic       pass_reg;
  wire        live = config_reset_n && transmit_reset_n && receive_reset_n && serdes_reg;
  wire        hit  = cfg_req && !cfg_done && wait_reg == (slow ? 3'd5 : 3'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done   <= 1'b0;
      wait_reg   <= 3'h0;
      up_reg     <= 4'h0;
      serdes_reg <= 1'b0;
      gen_reg    <= 1'b0;
      pass_reg   <= 1'b0;
    end else begin
      cfg_done <= hit;
      wait_reg <= (cfg_req && !cfg_done && !hit) ? wait_reg + 3'd1 : 3'd0;
      if (hit && cfg_op == 3'd0 && cfg_code == 16'h0001)
        serdes_reg <= cfg_value[0];
      if (hit && cfg_op == 3'd6)
        gen_reg <= cfg_value[0];
      up_reg   <= !live ? 4'h0 : (up_reg == 4'hF ? up_reg : up_reg + 4'd1);
      pass_reg <= live && gen_reg;
    end
  end

  // link comes up late when slow, so the wait loops really wait
  assign link_status_word = (up_reg > (slow ? 4'd9 : 4'd3)) ? {pass_reg, 3'b111} : 4'h0;
endmodule : rrseq_phy_model
`default_nettype wire

// >>> rate_reconfig_sequencer_tb.sv
// rate_reconfig_sequencer_tb.sv: walks start-up, every change among 24G fec, 24G and 10G, then 10G to 9.8G over apb
// assumes: phy model answers the config port; 20 MHz pclk
`timescale 1ns/1ns
`default_nettype none
module rate_reconfig_sequencer_tb;
  import rrseq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_value, ph, rd;
  logic        config_reset_n, transmit_reset_n, receive_reset_n, cfg_req, cfg_done, er;
  logic [2:0]  cfg_op;
  logic [15:0] cfg_code;
  logic [3:0]  link_status_word;
  logic [50:0] exp_q[$];
  int          errors, n_tests, seed;
  rrseq_mode_t cur;
  rrseq_mode_t walk[8] = '{RRSEQ_M24_NOFEC, RRSEQ_M10, RRSEQ_M24_FEC, RRSEQ_M10,
                           RRSEQ_M24_NOFEC, RRSEQ_M24_FEC, RRSEQ_M10, RRSEQ_M98};

  rate_reconfig_sequencer #(.RST_HOLD_NS(200)) rate_reconfig_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_reset_n(config_reset_n), .transmit_reset_n(transmit_reset_n),
    .receive_reset_n(receive_reset_n), .cfg_req(cfg_req), .cfg_op(cfg_op),
    .cfg_code(cfg_code), .cfg_value(cfg_value), .cfg_done(cfg_done),
    .link_status_word(link_status_word));
  rrseq_phy_model rrseq_phy_model_inst (
    .pclk(pclk), .presetn(presetn), .slow(slow), .config_reset_n(config_reset_n),
    .transmit_reset_n(transmit_reset_n), .receive_reset_n(receive_reset_n),
    .cfg_req(cfg_req), .cfg_op(cfg_op), .cfg_code(cfg_code), .cfg_value(cfg_value),
    .cfg_done(cfg_done), .link_status_word(link_status_word));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // checking and reporting
  // ****************************************
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  // value unchecked where the sequencer owns it (loopback, clear, analog reset)
  task cmp_cfg(input logic [50:0] got, input logic [50:0] exp);
    logic [50:0] m;
    case (exp[50:48])
      3'd0: m = (exp[47:32] == 16'h0008) ? {19'h7FFFF, 32'h0} : '1;
      3'd1, 3'd5: m = {3'h7, 48'h0};
      default: m = {3'h7, 16'h0, 32'hFFFFFFFF};
    endcase
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cfg

  always @(posedge pclk) begin
    if (presetn === 1'b1 && cfg_req === 1'b1 && cfg_done === 1'b1) begin
      if (exp_q.size() == 0) cmp32({29'h0, cfg_op}, 32'hFFFFFFFF);
      else cmp_cfg({cfg_op, cfg_code, cfg_value}, exp_q.pop_front());
    end
  end

  // ****************************************
  // apb master and sequence notes
  // ****************************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    er = pslverr;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task note(input logic [2:0] op, input logic [15:0] c, input logic [31:0] v);
    exp_q.push_back({op, c, v});
  endtask : note

  task link_notes;
    note(3'd5, 16'h0, 32'h0);
    note(3'd6, 16'h0, 32'h1);
    note(3'd6, 16'h0, 32'h0);
  endtask : link_notes

  task drain(input rrseq_mode_t to);
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    cmp32(32'(exp_q.size()), 32'h0);
    k = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    cmp32(rd, {20'h0, 4'h7, 2'h0, to, 4'h2});
    cur = to;
  endtask : drain

  task go(input rrseq_mode_t to);
    logic rat;
    rat = (cur == RRSEQ_M10 || to == RRSEQ_M10) && to != RRSEQ_M98;
    ph = $random(seed);
    rd = $random(seed);
    slow <= rd[0];
    apb(1'b1, 12'h014, ph);
    note(3'd0, 16'h0001, 32'h0);
    if (to == RRSEQ_M98)
      for (int s = 0; s < 3; s++) note(3'd7, 16'h0, 32'(s));
    note(3'd1, 16'h0, 32'h0);
    if (rat) begin
      note(3'd2, 16'h0, 32'(to));
      note(3'd3, 16'h0, 32'(to));
    end
    note(3'd4, 16'h0, 32'(to));
    note(3'd0, 16'h000E, ph);
    note(3'd0, 16'h0001, 32'h1);
    note(3'd0, 16'h0008, 32'h0);
    link_notes();
    apb(1'b1, 12'h000, {26'h0, to, 4'h1});
    repeat (4) @(posedge pclk);
    // a second order while busy must be dropped
    apb(1'b1, 12'h000, {26'h0, ~to, 4'h1});
    drain(to);
  endtask : go

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    seed = 32'h5060846b;
    presetn = 1'b0;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    errors = 0;
    n_tests = 0;
    cur = RRSEQ_M24_FEC;
    repeat (6) @(posedge pclk);
    cmp32({29'h0, config_reset_n, transmit_reset_n, receive_reset_n}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    cmp32(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    cmp32({rd[31:1], er}, 32'h1);
    note(3'd0, 16'h0001, 32'h1);
    link_notes();
    apb(1'b1, 12'h000, 32'h0000_0100);
    drain(RRSEQ_M24_FEC);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    cmp32(rd, 32'h0000_0702);
    foreach (walk[i]) go(walk[i]);
    apb(1'b0, 12'h014, 32'h0);
    cmp32(rd, ph);
    give_verdict();
  end

  initial begin
    #(50 * 30000);
    errors++;
    give_verdict();
  end
endmodule : rate_reconfig_sequencer_tb
`default_nettype wire
